// [design/cadr_params.svh]
`ifndef CADR_PARAMS_SVH
`define CADR_PARAMS_SVH
// ==========================================
// Configuration indices
`define CADR_IDX_GAME 8'h1E
`define CADR_IDX_DTYPE 8'h1F
`define CADR_IDX_FDC 8'h20
`define CADR_IDX_RSV21 8'h21
`define CADR_IDX_PPSW 8'h22
`define CADR_IDX_PP 8'h23
`define CADR_IDX_SER1 8'h24
`define CADR_IDX_SER2 8'h25
`define CADR_IDX_DMA 8'h26
`define CADR_IDX_RSV_LO 8'h18
`define CADR_IDX_RSV_HI 8'h1D
// ==========================================
// Power-up values
`define CADR_RST_GAME 8'h80
`define CADR_RST_DTYPE 8'h00
`define CADR_RST_FDC 8'h3C
`define CADR_RST_PPSW 8'h00
`define CADR_RST_PP 8'h00
`define CADR_RST_SER 8'h00
`define CADR_RST_DMA 8'h00
// ==========================================
// Fields and codes
`define CADR_PPSW_MASK 8'h3F
`define CADR_GAME_OFF 2'h0
`define CADR_GAME_ONE 2'h1
`define CADR_GAME_EIGHT 2'h2
`define CADR_GAME_ONE_NIB 4'h1
`define CADR_DMA_NONE 4'hF
`define CADR_NUM_DRQ 4
`endif

// [design/cadr_pkg.sv]
package cadr_pkg;
  // ==========================================
  // Configuration access from the index port logic
  typedef struct packed {
    logic mode;
    logic wr;
    logic rd;
    logic [7:0] index;
    logic [7:0] wdata;
  } cadr_cfg_req_t;
  // ==========================================
  // Host I/O cycle address
  typedef struct packed {
    logic cs_n;
    logic [10:0] addr;
  } cadr_io_t;
  // ==========================================
  // Function selects
  typedef struct packed {
    logic fdc;
    logic pp;
    logic ser1;
    logic ser2;
  } cadr_sel_t;
  typedef enum logic [1:0] {
    CADR_DT_DENS,
    CADR_DT_RATE10,
    CADR_DT_DENS_INV,
    CADR_DT_RATE01
  } cadr_dtype_t;
endpackage

// [design/cadr_top.sv]
`timescale 1ns/1ns
`default_nettype none
`include "cadr_params.svh"

// Summary of operation
// RULE1: Force-write-protect with a drive selected asserts write-protect on both floppy paths.
// RULE2: Indices 18h-1Dh and 21h ignore writes and read zero.
// RULE3: Registers accessed only in configuration state at their loaded index.
// RULE4: Game select base resets 80h, bits 7:2 hold address 9:4.
// RULE5: Game low bits: off, one byte 0001b, eight byte 0XXXb, sixteen byte.
// RULE6: Game select needs chip-select low and A10 low.
// RULE7: Power-good/game control overrides the game decode configuration.
// RULE8: Drive type register resets 00h, two bits per drive, high bit first.
// RULE9: Type code maps density and rate signals onto the two density pins.
// RULE10: Density mapping uses the type of the currently selected drive.
// RULE11: Floppy base resets 3Ch, address 9:4; host writes low bits zero.
// RULE12: Floppy select needs chip-select low, A10 low, base match, A3 zero.
// RULE13: Base address bits 9 and 8 both zero disable that function.
// RULE14: Parallel soft select resets 00h, software only, no routing effect.
// RULE15: Parallel base resets 00h, address 9:2, four-byte blocks without EPP.
// RULE16: With EPP, parallel base on eight-byte blocks, A2:0 free.
// RULE17: Parallel needs A10 low except in ECP mode.
// RULE18: Serial bases reset 00h, address 9:3; host writes bit 0 zero.
// RULE19: Serial select needs chip-select low, A10 low, bits 9:3 match.
// RULE20: DMA select: floppy 7:4, parallel 3:0, codes 0-3 channels, Fh none.
// RULE21: Unselected DMA request outputs are released.
// RULE22: Base matching is combinational on every I/O cycle.
module cadr_top (
  input wire logic CLOCK, // 25 MHz host clock
  input wire logic NRST, // Synchronous reset, active low
  input wire cadr_pkg::cadr_cfg_req_t CFG_REQ, // Configuration access
  output logic [7:0] CFG_RDATA, // Configuration read data
  input wire cadr_pkg::cadr_io_t IO, // Host I/O cycle address
  input wire logic POWER_GOOD_GAME_CTL, // 1: pin is power-good, no game select
  input wire logic PP_EPP_EN, // Parallel EPP mode enabled
  input wire logic PP_ECP_MODE, // Parallel ECP mode
  output logic GAME_PORT_SELECT_N, // Game port select, active low
  output cadr_pkg::cadr_sel_t FUNC_SEL, // Function register selects
  input wire logic FORCE_WRITE_PROTECT, // Force write-protect control bit
  input wire logic DRIVE_ACTIVE, // Some drive is selected
  input wire logic [1:0] DRIVE_NUM, // Selected drive number
  input wire logic WRITE_PROTECT_IN_N, // Floppy interface pin
  input wire logic PP_WRITE_PROTECT_IN_N, // Parallel-port floppy pin
  output logic WRITE_PROTECT_N, // To controller, floppy path
  output logic PP_WRITE_PROTECT_N, // To controller, parallel path
  input wire logic DENSITY_SELECT, // Controller density select
  input wire logic RATE_SEL_0, // Controller rate bit 0
  input wire logic RATE_SEL_1, // Controller rate bit 1
  output logic DRIVE_DENSITY_PIN0, // Density pin 0
  output logic DRIVE_DENSITY_PIN1, // Density pin 1
  input wire logic FDC_DRQ, // Floppy DMA request
  input wire logic PP_DRQ, // Parallel DMA request
  output logic [3:0] DRQ_O, // DMA request lines A-D
  output logic [3:0] DRQ_OE // Drive enables for DRQ_O
);

  // ==========================================
  // Helpers
  function automatic logic base_on(input logic [7:0] r);
    base_on = (r[7:6] != 2'h0);
  endfunction

  function automatic logic chan_hit(input logic [3:0] code, input int ch);
    chan_hit = (code == 4'(ch));
  endfunction

  // ==========================================
  // Registers
  logic [7:0] game_port_select_base_r;
  logic [7:0] drive_type_map_r;
  logic [7:0] floppy_base_addr_r;
  logic [7:0] parallel_soft_select_r;
  logic [7:0] parallel_base_addr_r;
  logic [7:0] serial1_base_addr_r;
  logic [7:0] serial2_base_addr_r;
  logic [7:0] floppy_parallel_dma_select_r;
  logic [7:0] rdata_nxt;
  logic wr_en;
  logic rd_en;

  assign wr_en = CFG_REQ.mode && CFG_REQ.wr; // RULE3
  assign rd_en = CFG_REQ.mode && CFG_REQ.rd; // RULE3

  // Reserved indices have no storage, so writes to them fall away
  always_ff @(posedge CLOCK)
  begin
    if (!NRST)
    begin
      game_port_select_base_r <= `CADR_RST_GAME; // RULE4
      drive_type_map_r <= `CADR_RST_DTYPE; // RULE8
      floppy_base_addr_r <= `CADR_RST_FDC; // RULE11
      parallel_soft_select_r <= `CADR_RST_PPSW; // RULE14
      parallel_base_addr_r <= `CADR_RST_PP; // RULE15
      serial1_base_addr_r <= `CADR_RST_SER; // RULE18
      serial2_base_addr_r <= `CADR_RST_SER; // RULE18
      floppy_parallel_dma_select_r <= `CADR_RST_DMA; // RULE20
    end
    else if (wr_en)
    begin
      unique case (CFG_REQ.index)
        `CADR_IDX_GAME: game_port_select_base_r <= CFG_REQ.wdata;
        `CADR_IDX_DTYPE: drive_type_map_r <= CFG_REQ.wdata;
        `CADR_IDX_FDC: floppy_base_addr_r <= CFG_REQ.wdata;
        `CADR_IDX_PPSW: parallel_soft_select_r <= CFG_REQ.wdata & `CADR_PPSW_MASK;
        `CADR_IDX_PP: parallel_base_addr_r <= CFG_REQ.wdata;
        `CADR_IDX_SER1: serial1_base_addr_r <= CFG_REQ.wdata;
        `CADR_IDX_SER2: serial2_base_addr_r <= CFG_REQ.wdata;
        `CADR_IDX_DMA: floppy_parallel_dma_select_r <= CFG_REQ.wdata;
        default:
        begin
        end
      endcase
    end
  end

  // ==========================================
  // Read path
  always_comb
  begin
    rdata_nxt = 8'h00; // RULE2
    unique case (CFG_REQ.index)
      `CADR_IDX_GAME: rdata_nxt = game_port_select_base_r;
      `CADR_IDX_DTYPE: rdata_nxt = drive_type_map_r;
      `CADR_IDX_FDC: rdata_nxt = floppy_base_addr_r;
      `CADR_IDX_PPSW: rdata_nxt = parallel_soft_select_r;
      `CADR_IDX_PP: rdata_nxt = parallel_base_addr_r;
      `CADR_IDX_SER1: rdata_nxt = serial1_base_addr_r;
      `CADR_IDX_SER2: rdata_nxt = serial2_base_addr_r;
      `CADR_IDX_DMA: rdata_nxt = floppy_parallel_dma_select_r;
      default: rdata_nxt = 8'h00;
    endcase
  end

  // Read data holds until the next read
  always_ff @(posedge CLOCK)
  begin
    if (!NRST)
      CFG_RDATA <= 8'h00;
    else if (rd_en)
      CFG_RDATA <= rdata_nxt; // RULE3
  end

  // ==========================================
  // Address decode, combinational for the whole I/O cycle
  logic io_ok;
  logic game_low;
  logic game_hit;
  logic pp_hit;

  assign io_ok = !IO.cs_n && !IO.addr[10]; // RULE6 RULE22

  always_comb
  begin
    unique case (game_port_select_base_r[1:0])
      `CADR_GAME_OFF: game_low = 1'b0;
      `CADR_GAME_ONE: game_low = (IO.addr[3:0] == `CADR_GAME_ONE_NIB);
      `CADR_GAME_EIGHT: game_low = !IO.addr[3];
      default: game_low = 1'b1;
    endcase
  end

  // RULE5
  assign game_hit = io_ok && game_low
    && (IO.addr[9:4] == game_port_select_base_r[7:2]); // RULE4 RULE6
  // Pin shared with power-good; control bit wins outright
  assign GAME_PORT_SELECT_N = !(game_hit && !POWER_GOOD_GAME_CTL); // RULE7

  always_comb
  begin
    if (PP_EPP_EN)
      pp_hit = (IO.addr[9:3] == parallel_base_addr_r[7:1]); // RULE16
    else
      pp_hit = (IO.addr[9:2] == parallel_base_addr_r); // RULE15
  end

  // One process drives the whole select word; ECP uses A10 for its upper bank
  always_comb
  begin
    FUNC_SEL.fdc = io_ok && base_on(floppy_base_addr_r) // RULE13
      && (IO.addr[9:4] == floppy_base_addr_r[7:2]) && !IO.addr[3]; // RULE12
    FUNC_SEL.pp = !IO.cs_n && (PP_ECP_MODE || !IO.addr[10]) // RULE17
      && base_on(parallel_base_addr_r) && pp_hit; // RULE13
    FUNC_SEL.ser1 = io_ok && base_on(serial1_base_addr_r) // RULE13
      && (IO.addr[9:3] == serial1_base_addr_r[7:1]); // RULE19
    FUNC_SEL.ser2 = io_ok && base_on(serial2_base_addr_r) // RULE13
      && (IO.addr[9:3] == serial2_base_addr_r[7:1]); // RULE19
  end

  // ==========================================
  // Write protect
  logic [1:0] wp_meta_r;
  logic [1:0] wp_sync_r;
  logic force_wp;

  always_ff @(posedge CLOCK)
  begin
    if (!NRST)
    begin
      wp_meta_r <= 2'h3;
      wp_sync_r <= 2'h3;
    end
    else
    begin
      wp_meta_r <= {PP_WRITE_PROTECT_IN_N, WRITE_PROTECT_IN_N};
      wp_sync_r <= wp_meta_r;
    end
  end

  assign force_wp = FORCE_WRITE_PROTECT && DRIVE_ACTIVE; // RULE1
  assign WRITE_PROTECT_N = wp_sync_r[0] && !force_wp; // RULE1
  assign PP_WRITE_PROTECT_N = wp_sync_r[1] && !force_wp; // RULE1

  // ==========================================
  // Drive density pins
  cadr_pkg::cadr_dtype_t dtype;
  logic pin0_nxt;
  logic pin1_nxt;

  // High bit of each pair is the first type bit
  assign dtype = cadr_pkg::cadr_dtype_t'({drive_type_map_r[{DRIVE_NUM, 1'b1}],
    drive_type_map_r[{DRIVE_NUM, 1'b0}]}); // RULE8 RULE10

  always_comb
  begin
    unique case (dtype) // RULE9
      cadr_pkg::CADR_DT_DENS:
      begin
        pin0_nxt = DENSITY_SELECT;
        pin1_nxt = RATE_SEL_0;
      end
      cadr_pkg::CADR_DT_RATE10:
      begin
        pin0_nxt = RATE_SEL_1;
        pin1_nxt = RATE_SEL_0;
      end
      cadr_pkg::CADR_DT_DENS_INV:
      begin
        pin0_nxt = !DENSITY_SELECT;
        pin1_nxt = RATE_SEL_0;
      end
      cadr_pkg::CADR_DT_RATE01:
      begin
        pin0_nxt = RATE_SEL_0;
        pin1_nxt = RATE_SEL_1;
      end
    endcase
  end

  always_ff @(posedge CLOCK)
  begin
    if (!NRST)
    begin
      DRIVE_DENSITY_PIN0 <= 1'b0;
      DRIVE_DENSITY_PIN1 <= 1'b0;
    end
    else
    begin
      DRIVE_DENSITY_PIN0 <= pin0_nxt; // RULE9
      DRIVE_DENSITY_PIN1 <= pin1_nxt; // RULE9
    end
  end

  // ==========================================
  // DMA request routing
  // Soft select register feeds nothing here, only the read path
  logic [3:0] fdc_code;
  logic [3:0] pp_code;
  logic [3:0] drq_nxt;
  logic [3:0] oe_nxt;

  assign fdc_code = floppy_parallel_dma_select_r[7:4]; // RULE20
  assign pp_code = floppy_parallel_dma_select_r[3:0]; // RULE20 RULE14

  // Reserved codes match no channel, so they act like none
  always_comb
  begin
    for (int ch = 0; ch < `CADR_NUM_DRQ; ch++)
    begin
      oe_nxt[ch] = chan_hit(fdc_code, ch) || chan_hit(pp_code, ch); // RULE21
      drq_nxt[ch] = (chan_hit(fdc_code, ch) && FDC_DRQ)
        || (chan_hit(pp_code, ch) && PP_DRQ);
    end
  end

  always_ff @(posedge CLOCK)
  begin
    if (!NRST)
    begin
      DRQ_O <= 4'h0;
      DRQ_OE <= 4'h0;
    end
    else
    begin
      DRQ_O <= drq_nxt; // RULE20
      DRQ_OE <= oe_nxt; // RULE21
    end
  end

  // ==========================================
  // Checks
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!NRST);

  a_cfg_write_gate: assert property ( // RULE3
    !CFG_REQ.mode |=> $stable(game_port_select_base_r) && $stable(drive_type_map_r)
      && $stable(floppy_parallel_dma_select_r))
    else $error("Register changed outside configuration state");

  a_reserved_reads: assert property ( // RULE2
    rd_en && (CFG_REQ.index == `CADR_IDX_RSV21
      || (CFG_REQ.index >= `CADR_IDX_RSV_LO && CFG_REQ.index <= `CADR_IDX_RSV_HI))
    |=> CFG_RDATA == 8'h00)
    else $error("Reserved index read nonzero");

  a_game_readback: assert property ( // RULE4
    wr_en && CFG_REQ.index == `CADR_IDX_GAME ##1 !wr_en
      ##1 rd_en && CFG_REQ.index == `CADR_IDX_GAME && !CFG_REQ.wr
    |=> CFG_RDATA == $past(CFG_REQ.wdata, 3))
    else $error("Game base readback mismatch");

  a_game_qualify: assert property ( // RULE6
    (IO.cs_n || IO.addr[10] || POWER_GOOD_GAME_CTL) |-> GAME_PORT_SELECT_N)
    else $error("Game select without qualification");

  a_game_disabled: assert property ( // RULE5
    game_port_select_base_r[1:0] == `CADR_GAME_OFF |-> GAME_PORT_SELECT_N)
    else $error("Game select while disabled");

  a_fdc_decode: assert property ( // RULE12
    FUNC_SEL.fdc |-> !IO.addr[3] && !IO.cs_n && floppy_base_addr_r[7:6] != 2'h0)
    else $error("Floppy select on bad address");

  a_serial_decode: assert property ( // RULE19
    FUNC_SEL.ser1 |-> !IO.addr[10] && IO.addr[9:3] == serial1_base_addr_r[7:1])
    else $error("Serial 1 select on bad address");

  a_force_wp: assert property ( // RULE1
    FORCE_WRITE_PROTECT && DRIVE_ACTIVE |-> !WRITE_PROTECT_N && !PP_WRITE_PROTECT_N)
    else $error("Forced write protect not asserted");

  a_density_map: assert property ( // RULE9
    dtype == cadr_pkg::CADR_DT_RATE01 |=> DRIVE_DENSITY_PIN0 == $past(RATE_SEL_0)
      && DRIVE_DENSITY_PIN1 == $past(RATE_SEL_1))
    else $error("Density pin mapping wrong");

  a_dma_release: assert property ( // RULE21
    floppy_parallel_dma_select_r == {`CADR_DMA_NONE, `CADR_DMA_NONE}
      ##1 floppy_parallel_dma_select_r == {`CADR_DMA_NONE, `CADR_DMA_NONE}
    |-> DRQ_OE == 4'h0)
    else $error("DMA line driven while unselected");

  a_rdata_hold: assert property ( // RULE3
    !rd_en |=> $stable(CFG_RDATA))
    else $error("Read data moved without a read");

  a_wp_release: assert property ( // RULE1
    !FORCE_WRITE_PROTECT && wp_sync_r == 2'h3 |-> WRITE_PROTECT_N && PP_WRITE_PROTECT_N)
    else $error("Write protect asserted without cause");

  a_pp_decode: assert property ( // RULE17
    FUNC_SEL.pp && !PP_ECP_MODE |-> !IO.addr[10] && !IO.cs_n)
    else $error("Parallel select on bad address");

  a_dma_route: assert property ( // RULE20
    floppy_parallel_dma_select_r[7:4] == 4'h0 && FDC_DRQ |=> DRQ_O[0] && DRQ_OE[0])
    else $error("Floppy request not routed to channel A");

endmodule
`default_nettype wire

// [testbench/cadr_host_model.sv]
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// Host side of the I/O cycle
module cadr_host_model (
  input wire logic clk, // Host clock
  input wire logic go, // I/O cycle in progress
  input wire logic [10:0] addr, // Cycle address
  output cadr_pkg::cadr_io_t io // To the decoder
);
  logic [10:0] last_r = 11'h000;
  always_ff @(posedge clk)
  begin
    if (go)
      last_r <= addr;
  end
  // Idle bus never shows the stale address
  always_comb
  begin
    io.cs_n = !go;
    io.addr = go ? addr : ~last_r;
  end
endmodule
`default_nettype wire

// [testbench/tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  cadr_pkg::cadr_cfg_req_t req = '0;
  cadr_pkg::cadr_io_t io;
  cadr_pkg::cadr_sel_t sel;
  logic [7:0] rdata;
  logic go = 1'b0;
  logic [10:0] addr = 11'h000;
  logic pg = 1'b0, epp = 1'b0, ecp = 1'b0, fwp = 1'b0, dact = 1'b0;
  logic [1:0] dnum = 2'h0;
  logic wp_pin_n = 1'b1, pp_pin_n = 1'b1;
  logic dens = 1'b1, r0 = 1'b0, r1 = 1'b1, fdrq = 1'b0, pdrq = 1'b0;
  logic game_n, wp_n, pp_wp_n, dd0, dd1;
  logic [3:0] drq, drq_oe;
  logic [1:0] code;
  logic [7:0] ri;
  int bad_count = 0;
  int n_checks = 0;
  int cycles = 0;
  logic [7:0] idx_t [8] = '{8'h1E, 8'h1F, 8'h20, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26};
  logic [7:0] rst_t [8] = '{8'h80, 8'h00, 8'h3C, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] dma_t [4] = '{8'hFF, 8'h1F, 8'h42, 8'h03};
  logic [3:0] oe_t [4] = '{4'h0, 4'h2, 4'h4, 4'h9};

  initial
  begin
    forever #20 clk = ~clk;
  end

  cadr_host_model host (.clk(clk), .go(go), .addr(addr), .io(io));

  cadr_top uut (
    .CLOCK(clk), .NRST(nrst), .CFG_REQ(req), .CFG_RDATA(rdata), .IO(io),
    .POWER_GOOD_GAME_CTL(pg), .PP_EPP_EN(epp), .PP_ECP_MODE(ecp),
    .GAME_PORT_SELECT_N(game_n), .FUNC_SEL(sel), .FORCE_WRITE_PROTECT(fwp),
    .DRIVE_ACTIVE(dact), .DRIVE_NUM(dnum), .WRITE_PROTECT_IN_N(wp_pin_n),
    .PP_WRITE_PROTECT_IN_N(pp_pin_n), .WRITE_PROTECT_N(wp_n),
    .PP_WRITE_PROTECT_N(pp_wp_n), .DENSITY_SELECT(dens), .RATE_SEL_0(r0),
    .RATE_SEL_1(r1), .DRIVE_DENSITY_PIN0(dd0), .DRIVE_DENSITY_PIN1(dd1),
    .FDC_DRQ(fdrq), .PP_DRQ(pdrq), .DRQ_O(drq), .DRQ_OE(drq_oe)
  );

  // ==========================================
  // Checking and bus tasks
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  // One strobe cycle; read data lands on the edge that ends the strobe, one edge after it is driven
  task automatic cfg(input logic m, input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk);
    req <= '{mode: m, wr: w, rd: !w, index: idx, wdata: d};
    @(posedge clk);
    req <= '{mode: m, wr: 1'b0, rd: 1'b0, index: idx, wdata: d};
    @(negedge clk);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] exp, input string nm);
    cfg(1'b1, 1'b0, idx, 8'h00);
    chk(nm, rdata, exp);
  endtask

  task automatic iochk(input logic c, input logic [10:0] a, input logic [7:0] es, input logic eg);
    @(posedge clk);
    go <= c;
    addr <= a;
    @(negedge clk);
    chk("func_sel", {4'h0, sel}, es);
    chk("game_sel_n", {7'h00, game_n}, {7'h00, eg});
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Cuts a hang short
  always @(posedge clk)
  begin
    cycles++;
    if (cycles > 20000)
    begin
      bad_count++;
      give_verdict();
    end
  end

  // ==========================================
  // Tests
  initial
  begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    for (int i = 0; i < 8; i++)
      rd(idx_t[i], rst_t[i], "reset_value");
    for (int i = 0; i < 7; i++)
    begin
      ri = (i < 6) ? 8'h18 + 8'(i) : 8'h21;
      cfg(1'b1, 1'b1, ri, 8'hFF);
      rd(ri, 8'h00, "reserved");
    end
    cfg(1'b0, 1'b1, 8'h26, 8'h55);
    rd(8'h26, 8'h00, "mode_off_write");
    $display("test registers done");
    for (int c = 0; c < 4; c++)
    begin
      code = 2'(c);
      cfg(1'b1, 1'b1, 8'h1E, {6'h30, code});
      rd(8'h1E, {6'h30, code}, "game_base");
      iochk(1'b1, 11'h301, 8'h00, code == 2'h0);
      iochk(1'b1, 11'h305, 8'h00, code < 2'h2);
      iochk(1'b1, 11'h30A, 8'h00, code != 2'h3);
      iochk(1'b1, 11'h311, 8'h00, 1'b1);
    end
    iochk(1'b0, 11'h301, 8'h00, 1'b1);
    iochk(1'b1, 11'h701, 8'h00, 1'b1);
    @(posedge clk);
    pg <= 1'b1;
    iochk(1'b1, 11'h301, 8'h00, 1'b1);
    $display("test game select done");
    cfg(1'b1, 1'b1, 8'h20, 8'hFC);
    iochk(1'b1, 11'h3F2, 8'h08, 1'b1);
    iochk(1'b1, 11'h3FA, 8'h00, 1'b1);
    iochk(1'b1, 11'h7F2, 8'h00, 1'b1);
    cfg(1'b1, 1'b1, 8'h20, 8'h00);
    iochk(1'b1, 11'h002, 8'h00, 1'b1);
    cfg(1'b1, 1'b1, 8'h23, 8'hDE);
    iochk(1'b1, 11'h37B, 8'h04, 1'b1);
    iochk(1'b1, 11'h37C, 8'h00, 1'b1);
    @(posedge clk);
    epp <= 1'b1;
    iochk(1'b1, 11'h37C, 8'h04, 1'b1);
    iochk(1'b1, 11'h380, 8'h00, 1'b1);
    iochk(1'b1, 11'h77B, 8'h00, 1'b1);
    @(posedge clk);
    ecp <= 1'b1;
    iochk(1'b1, 11'h77B, 8'h04, 1'b1);
    cfg(1'b1, 1'b1, 8'h24, 8'hFE);
    cfg(1'b1, 1'b1, 8'h25, 8'hBE);
    iochk(1'b1, 11'h3FF, 8'h02, 1'b1);
    iochk(1'b1, 11'h2F8, 8'h01, 1'b1);
    iochk(1'b1, 11'h6F8, 8'h00, 1'b1);
    @(posedge clk);
    go <= 1'b0;
    $display("test decode done");
    fwp <= 1'b1;
    dact <= 1'b1;
    @(negedge clk);
    chk("wp_forced", {6'h00, wp_n, pp_wp_n}, 8'h00);
    @(posedge clk);
    dact <= 1'b0;
    @(negedge clk);
    chk("wp_idle", {6'h00, wp_n, pp_wp_n}, 8'h03);
    @(posedge clk);
    wp_pin_n <= 1'b0;
    pp_pin_n <= 1'b0;
    @(negedge clk);
    chk("wp_pin_early", {6'h00, wp_n, pp_wp_n}, 8'h03);
    repeat (2) @(negedge clk);
    chk("wp_pin", {6'h00, wp_n, pp_wp_n}, 8'h00);
    @(posedge clk);
    wp_pin_n <= 1'b1;
    pp_pin_n <= 1'b1;
    fwp <= 1'b0;
    dact <= 1'b1;
    cfg(1'b1, 1'b1, 8'h1F, 8'h1B);
    for (int d = 0; d < 4; d++)
    begin
      code = 2'(8'h1B >> (2 * d));
      @(posedge clk);
      dnum <= 2'(d);
      repeat (2) @(negedge clk);
      chk("density", {6'h00, dd0, dd1}, {6'h00, code == 2'h0 ? {dens, r0} :
        code == 2'h1 ? {r1, r0} : code == 2'h2 ? {!dens, r0} : {r0, r1}});
    end
    $display("test drive done");
    @(posedge clk);
    fdrq <= 1'b1;
    pdrq <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      cfg(1'b1, 1'b1, 8'h26, dma_t[i]);
      repeat (2) @(negedge clk);
      chk("drq_oe", {4'h0, drq_oe}, {4'h0, oe_t[i]});
      chk("drq", {4'h0, drq & drq_oe}, {4'h0, oe_t[i]});
    end
    cfg(1'b1, 1'b1, 8'h22, 8'hFF);
    rd(8'h22, 8'h3F, "soft_select");
    chk("drq_oe_kept", {4'h0, drq_oe}, 8'h09);
    $display("test dma done");
    give_verdict();
  end
endmodule
`default_nettype wire
